// *** ocn_osc_map.svh ***
// register offsets, field positions, reset values and timing counts of the oscillator configuration bank
`ifndef OCN_OSC_MAP_SVH
`define OCN_OSC_MAP_SVH

// byte offsets seen on the serial register port
`define OCN_ADR_DIVIDER 8'h02
`define OCN_ADR_STEP_HI 8'h08
`define OCN_ADR_STEP_LO 8'h09
`define OCN_ADR_ADDR_CFG 8'h0D
`define OCN_ADR_BAND 8'h0E
`define OCN_ADR_FACTORY 8'h37
`define OCN_ADR_COMMIT 8'h3F

// nonvolatile image word indexes
`define OCN_NV_DIVIDER 3'h0
`define OCN_NV_STEP_HI 3'h1
`define OCN_NV_STEP_LO 3'h2
`define OCN_NV_BAND 3'h3
`define OCN_NV_ADDR 3'h4
`define OCN_NV_LAST 3'h4
`define OCN_NV_DEPTH 8
`define OCN_NV_AW 3

// dirty masks over the five image words
`define OCN_MASK_ALL 5'h1F
`define OCN_MASK_ADDR 5'h10
`define OCN_MASK_NONE 5'h00
`define OCN_MASK_ONE 5'h01

// factory defaults and fill patterns
`define OCN_RST_DIVIDER 8'hE0
`define OCN_RST_STEP_HI 8'h7D
`define OCN_RST_STEP_LO 8'h00
`define OCN_RST_ADDR 8'hF0
`define OCN_FACTORY_BAND 5'h12
`define OCN_FILL3 3'h7
`define OCN_FILL4 4'hF
`define OCN_RANGE_PAD 3'h0
`define OCN_STEP_PAD 6'h00
`define OCN_UNMAPPED 8'hFF

// field positions
`define OCN_EXP_MSB 3
`define OCN_DITHER_BIT 4
`define OCN_DEFER_BIT 3
`define OCN_BAND_MSB 4
`define OCN_EXP_MAX 4'h8

// master frequency arithmetic, in 10 kHz units
`define OCN_BAND_BASE_10KHZ 18'h02400
`define OCN_BAND_SHIFT 9
`define OCN_FREQ_MIN_10KHZ 16'h19C8
`define OCN_FREQ_MAX_10KHZ 16'h33F4

// nonvolatile write time
`define OCN_SYS_CLK_MHZ 20
`define OCN_NV_WRITE_TIME_US 5000
`define OCN_NV_WRITE_CYCLES (`OCN_NV_WRITE_TIME_US * `OCN_SYS_CLK_MHZ)

`endif

// *** ocn_pkg.sv ***
// types shared by the oscillator configuration bank
package ocn_pkg;
	// one register byte
	typedef logic [7:0] ocn_byte_t;
	// index into the nonvolatile image
	typedef logic [2:0] ocn_nv_idx_t;
	// sequencer for image load and nonvolatile commit
	typedef enum logic [2:0] {
		st_load = 3'b000,
		st_load_end = 3'b001,
		st_idle = 3'b010,
		st_write = 3'b011,
		st_wait = 3'b100
	} ocn_state_t;
endpackage

// *** ocn_nv_mem.sv ***
// nonvolatile image store with registered read data
`timescale 1ns/1ps
`include "ocn_osc_map.svh"
module ocn_nv_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `OCN_NV_DEPTH,
	parameter int AW = `OCN_NV_AW,
	parameter logic [WIDTH*DEPTH-1:0] INIT_IMAGE = '1
) (
	// clock, enable, reset
	input wire logic sys_clk,
	input wire logic ce,
	input wire logic rst,
	// write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// read port
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	// storage cells; not reset, they model cells that survive power loss
	logic [WIDTH-1:0] cells [0:DEPTH-1];

	// factory programmed contents
	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			cells[i] = INIT_IMAGE[i*WIDTH +: WIDTH];
		end
	end

	////////////////////////////////////////////////////////////////
	// write side
	always_ff @(posedge sys_clk) begin
		if (ce && wr_en) begin
			cells[wr_addr] <= wr_data;
		end
	end

	// read side, data held in a register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_data <= '0;
		end else if (ce && rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule

// *** ocn_config_regs.sv ***
// configuration register bank of the programmable oscillator with nonvolatile commit
`timescale 1ns/1ps
`include "ocn_osc_map.svh"
module ocn_config_regs #(
	parameter logic [4:0] FACTORY_BAND = `OCN_FACTORY_BAND,
	parameter int NV_WRITE_CYCLES = `OCN_NV_WRITE_CYCLES
) (
	// clock, enable, reset
	input wire logic sys_clk,
	input wire logic ce,
	input wire logic rst,
	// byte register port from the serial engine
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire ocn_pkg::ocn_byte_t reg_addr,
	input wire ocn_pkg::ocn_byte_t reg_wdata,
	output ocn_pkg::ocn_byte_t reg_rdata,
	output logic bus_ack,
	// oscillator settings
	output logic [4:0] band_select,
	output logic [9:0] step_value,
	output logic [3:0] divider_exponent,
	output logic dither_depth_select,
	output logic [15:0] master_freq_10khz,
	output logic freq_in_range,
	// serial address and memory status
	output logic slave_addr_bit2,
	output logic slave_addr_bit1,
	output logic slave_addr_bit0,
	output logic nv_write_defer,
	output logic nv_busy
);
	import ocn_pkg::*;

	////////////////////////////////////////////////////////////////
	// decoding helpers

	// maps a register offset to its image word; bit 3 marks a hit
	function automatic logic [3:0] addr_to_idx(input ocn_byte_t adr);
		logic [3:0] r;
		r = 4'h0;
		unique case (adr)
			`OCN_ADR_DIVIDER: r = {1'b1, `OCN_NV_DIVIDER};
			`OCN_ADR_STEP_HI: r = {1'b1, `OCN_NV_STEP_HI};
			`OCN_ADR_STEP_LO: r = {1'b1, `OCN_NV_STEP_LO};
			`OCN_ADR_BAND: r = {1'b1, `OCN_NV_BAND};
			`OCN_ADR_ADDR_CFG: r = {1'b1, `OCN_NV_ADDR};
			default: r = 4'h0;
		endcase
		return r;
	endfunction

	// lowest set bit of a dirty mask
	function automatic ocn_nv_idx_t first_set(input logic [4:0] m);
		ocn_nv_idx_t r;
		r = `OCN_NV_LAST;
		for (int i = 4; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// state
	ocn_state_t state; // sequencer state
	ocn_state_t next_state;
	ocn_nv_idx_t ld_idx; // next image word to fetch at start up
	ocn_nv_idx_t next_ld_idx;
	logic cap_valid; // fetched word arrives this cycle
	ocn_nv_idx_t cap_idx; // which word arrives
	logic [31:0] wait_cnt; // cycles spent in the memory write
	logic [31:0] next_wait_cnt;
	logic [4:0] dirty; // words changed since last save
	logic [4:0] next_dirty;
	logic flush; // commit pending, save everything
	logic next_flush;
	logic [3:0] exp_field; // raw exponent as written
	logic [2:0] slave_addr; // low slave address bits

	// memory port
	logic mem_wr;
	ocn_nv_idx_t mem_waddr;
	ocn_byte_t mem_rdata;
	logic [4:0] clr_mask; // words saved this cycle

	// decode wires
	wire [3:0] dec = addr_to_idx(reg_addr);
	wire dec_hit = dec[3];
	wire ocn_nv_idx_t dec_idx = dec[2:0];
	// writes are refused while the memory is busy, so a host must defer or wait
	wire wr_ok = ce & reg_wr & ~nv_busy;
	wire wr_hit = wr_ok & dec_hit;
	// commit is taken from the offset alone, any data byte is ignored
	wire commit_hit = wr_ok & (reg_addr == `OCN_ADR_COMMIT);
	wire [4:0] wr_onehot = wr_hit ? 5'(`OCN_MASK_ONE << dec_idx) : `OCN_MASK_NONE;
	wire [4:0] cap_onehot = cap_valid ? 5'(`OCN_MASK_ONE << cap_idx) : `OCN_MASK_NONE;
	wire [4:0] upd = wr_onehot | cap_onehot; // load and host writes never overlap
	wire ocn_byte_t src = cap_valid ? mem_rdata : reg_wdata;
	// commit marks every word dirty
	wire [4:0] set_mask = commit_hit ? `OCN_MASK_ALL : wr_onehot;
	// without defer every word may go; with defer only the address word, unless committing
	wire [4:0] allow = (flush | ~nv_write_defer) ? `OCN_MASK_ALL : `OCN_MASK_ADDR;
	wire [4:0] eligible = dirty & allow;
	wire ocn_nv_idx_t save_idx = first_set(eligible);
	wire [4:0] save_onehot = 5'(`OCN_MASK_ONE << save_idx);
	wire [4:0] wd_band = reg_wdata[4:0];
	wire [2:0] wd_saddr = reg_wdata[2:0];

	// image words as they would be saved and read back
	ocn_byte_t nv_words [0:7];
	assign nv_words[0] = {`OCN_FILL3, dither_depth_select, exp_field};
	assign nv_words[1] = step_value[9:2];
	assign nv_words[2] = {step_value[1:0], `OCN_STEP_PAD};
	assign nv_words[3] = {`OCN_FILL3, band_select};
	assign nv_words[4] = {`OCN_FILL4, nv_write_defer, slave_addr};
	genvar gi;
	generate
		for (gi = 5; gi < 8; gi++) begin : g_pad
			assign nv_words[gi] = `OCN_UNMAPPED;
		end
	endgenerate

	// the factory copy is a constant, never a stored register
	wire ocn_byte_t factory_word = {`OCN_RANGE_PAD, FACTORY_BAND};
	wire ocn_byte_t rd_image = (reg_addr == `OCN_ADR_FACTORY) ? factory_word :
		(dec_hit ? nv_words[dec_idx] : `OCN_UNMAPPED);

	localparam logic [63:0] INIT_IMAGE = {`OCN_UNMAPPED, `OCN_UNMAPPED, `OCN_UNMAPPED, `OCN_RST_ADDR,
		`OCN_FILL3, FACTORY_BAND, `OCN_RST_STEP_LO, `OCN_RST_STEP_HI, `OCN_RST_DIVIDER};
	localparam logic [31:0] WAIT_LAST = 32'(NV_WRITE_CYCLES - 1);

	////////////////////////////////////////////////////////////////
	// nonvolatile image
	ocn_nv_mem #(
		.WIDTH(8),
		.DEPTH(`OCN_NV_DEPTH),
		.AW(`OCN_NV_AW),
		.INIT_IMAGE(INIT_IMAGE)
	) u_nv_mem (
		.sys_clk(sys_clk),
		.ce(ce),
		.rst(rst),
		.wr_en(mem_wr),
		.wr_addr(mem_waddr),
		.wr_data(nv_words[mem_waddr]),
		.rd_en(state == st_load),
		.rd_addr(ld_idx),
		.rd_data(mem_rdata)
	);

	////////////////////////////////////////////////////////////////
	// sequencer: fetch image after reset, then save dirty words
	always_comb begin
		next_state = state;
		next_ld_idx = ld_idx;
		next_wait_cnt = wait_cnt;
		next_flush = flush | commit_hit;
		mem_wr = 1'b0;
		mem_waddr = save_idx;
		clr_mask = `OCN_MASK_NONE;
		unique case (state)
			st_load: begin
				next_ld_idx = 3'(ld_idx + 3'h1);
				if (ld_idx == `OCN_NV_LAST) begin
					next_state = st_load_end;
				end
			end
			// last fetched word lands here
			st_load_end: begin
				next_state = st_idle;
			end
			st_idle: begin
				if (eligible != `OCN_MASK_NONE) begin
					next_state = st_write;
				end
			end
			// one word per cycle, then one shared write time
			st_write: begin
				mem_wr = 1'b1;
				clr_mask = save_onehot;
				if ((eligible & ~save_onehot) == `OCN_MASK_NONE) begin
					next_state = st_wait;
					next_flush = 1'b0;
					next_wait_cnt = 32'h0;
				end
			end
			st_wait: begin
				next_wait_cnt = 32'(wait_cnt + 32'h1);
				if (wait_cnt >= WAIT_LAST) begin
					next_state = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		// a new change beats a clear in the same cycle
		next_dirty = (dirty & ~clr_mask) | set_mask;
	end

	// sequencer registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= st_load;
			ld_idx <= 3'h0;
			wait_cnt <= 32'h0;
			flush <= 1'b0;
			dirty <= `OCN_MASK_NONE;
		end else if (ce) begin
			state <= next_state;
			ld_idx <= next_ld_idx;
			wait_cnt <= next_wait_cnt;
			flush <= next_flush;
			dirty <= next_dirty;
		end
	end

	// capture marker for the registered memory read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cap_valid <= 1'b0;
			cap_idx <= 3'h0;
		end else if (ce) begin
			cap_valid <= (state == st_load);
			cap_idx <= ld_idx;
		end
	end

	// writes are refused and bus_ack drops while loading or saving; reads still update reg_rdata
	assign nv_busy = (state != st_idle);
	assign bus_ack = ~nv_busy;

	////////////////////////////////////////////////////////////////
	// working registers, loaded from the image or written by the host

	// exponent and dither select
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			exp_field <= 4'(`OCN_RST_DIVIDER);
			dither_depth_select <= 1'(`OCN_RST_DIVIDER >> `OCN_DITHER_BIT);
		end else if (ce && upd[`OCN_NV_DIVIDER]) begin
			exp_field <= src[`OCN_EXP_MSB:0];
			dither_depth_select <= src[`OCN_DITHER_BIT];
		end
	end

	// step value, high byte then low two bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			step_value <= {`OCN_RST_STEP_HI, 2'(`OCN_RST_STEP_LO >> 6)};
		end else if (ce) begin
			if (upd[`OCN_NV_STEP_HI]) begin
				step_value[9:2] <= src;
			end
			if (upd[`OCN_NV_STEP_LO]) begin
				step_value[1:0] <= src[7:6];
			end
		end
	end

	// band select, five bits wide like the factory value
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			band_select <= FACTORY_BAND;
		end else if (ce && upd[`OCN_NV_BAND]) begin
			band_select <= src[`OCN_BAND_MSB:0];
		end
	end

	// slave address bits and defer flag
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slave_addr <= 3'(`OCN_RST_ADDR);
			nv_write_defer <= 1'(`OCN_RST_ADDR >> `OCN_DEFER_BIT);
		end else if (ce && upd[`OCN_NV_ADDR]) begin
			slave_addr <= src[2:0];
			nv_write_defer <= src[`OCN_DEFER_BIT];
		end
	end
	assign slave_addr_bit2 = slave_addr[2];
	assign slave_addr_bit1 = slave_addr[1];
	assign slave_addr_bit0 = slave_addr[0];

	// read data, unmapped offsets read as idle bus
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= `OCN_UNMAPPED;
		end else if (ce && reg_rd) begin
			reg_rdata <= rd_image;
		end
	end

	////////////////////////////////////////////////////////////////
	// derived oscillator settings; registered, so they trail the registers by a cycle

	// band base moves 512 steps per band away from the factory band; clamp below zero
	wire [17:0] freq_up = `OCN_BAND_BASE_10KHZ + (18'(band_select) << `OCN_BAND_SHIFT) + 18'(step_value);
	wire [17:0] freq_dn = 18'(FACTORY_BAND) << `OCN_BAND_SHIFT;
	wire [15:0] freq_calc = (freq_up >= freq_dn) ? 16'(freq_up - freq_dn) : 16'h0000;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divider_exponent <= 4'h0;
			master_freq_10khz <= 16'h0000;
			freq_in_range <= 1'b0;
		end else if (ce) begin
			divider_exponent <= (exp_field > `OCN_EXP_MAX) ? `OCN_EXP_MAX : exp_field;
			master_freq_10khz <= freq_calc;
			// flags settings inside the span the oscillator is good for
			freq_in_range <= (freq_calc >= `OCN_FREQ_MIN_10KHZ) && (freq_calc <= `OCN_FREQ_MAX_10KHZ);
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking ocn_cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_exp_clamp: assert property (ce && exp_field > `OCN_EXP_MAX |=> divider_exponent == `OCN_EXP_MAX)
		else $error("exponent above eight not clamped");
	a_factory_read: assert property (ce && reg_rd && reg_addr == `OCN_ADR_FACTORY |=> reg_rdata == factory_word)
		else $error("factory copy read wrong");
	a_factory_ro: assert property (ce && reg_wr && reg_addr == `OCN_ADR_FACTORY |-> set_mask == `OCN_MASK_NONE)
		else $error("factory copy accepted a write");
	a_band_store: assert property (wr_ok && reg_addr == `OCN_ADR_BAND |=> band_select == $past(wd_band))
		else $error("band select not stored");
	a_step_left: assert property (wr_ok && reg_addr == `OCN_ADR_STEP_HI |=> step_value[9:2] == $past(reg_wdata))
		else $error("step high byte misplaced");
	a_divider_fields: assert property (wr_ok && reg_addr == `OCN_ADR_DIVIDER && reg_wdata == 8'h13 |=>
		dither_depth_select ##1 divider_exponent == 4'h3)
		else $error("divider byte decoded wrong");
	a_slave_bits: assert property (wr_ok && reg_addr == `OCN_ADR_ADDR_CFG |=>
		{slave_addr_bit2, slave_addr_bit1, slave_addr_bit0} == $past(wd_saddr))
		else $error("slave address bits not taken");
	a_addr_immediate: assert property (wr_ok && reg_addr == `OCN_ADR_ADDR_CFG |-> ##[1:3] nv_busy)
		else $error("address write not saved at once");
	a_auto_save: assert property (wr_ok && reg_addr == `OCN_ADR_BAND && !nv_write_defer |-> ##[1:3] nv_busy)
		else $error("automatic save did not start");
	a_defer_hold: assert property (wr_ok && reg_addr == `OCN_ADR_BAND && nv_write_defer |-> ##2 !nv_busy)
		else $error("deferred write saved early");
	a_commit_marks: assert property (commit_hit |=> dirty == `OCN_MASK_ALL && flush ##[1:2] nv_busy)
		else $error("commit did not save all words");
	a_busy_refuse: assert property (nv_busy && reg_wr |-> !bus_ack && set_mask == `OCN_MASK_NONE)
		else $error("transfer accepted while busy");
	a_band_base: assert property (ce && band_select == FACTORY_BAND && step_value == 10'h000 |=>
		master_freq_10khz == 16'(`OCN_BAND_BASE_10KHZ))
		else $error("factory band base wrong");

	c_commit: cover property (commit_hit ##[1:3] nv_busy);
	c_auto: cover property (wr_ok && reg_addr == `OCN_ADR_STEP_HI && !nv_write_defer ##[1:3] nv_busy);
	c_clamp: cover property (ce && exp_field > `OCN_EXP_MAX);
	c_release: cover property ($fell(nv_busy));
endmodule

// *** ocn_host_model.sv ***
// host-side model driving the byte register port of the oscillator configuration bank
`timescale 1ns/1ps
module ocn_host_model (
	// clock and save status from the bank
	input wire logic sys_clk,
	input wire logic bus_ack,
	// byte register port
	output logic reg_wr,
	output logic reg_rd,
	output ocn_pkg::ocn_byte_t reg_addr,
	output ocn_pkg::ocn_byte_t reg_wdata
);
	import ocn_pkg::*;
	// expected read data, oldest first
	ocn_byte_t exp_q[$];

	////////////////////////////////////////////////////////////////
	// idle lines at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'hA5;
		reg_wdata = 8'h5A;
	end

	// one byte write; wait_ack=0 skips the wait, used to provoke a refusal or to write with the enable low
	task automatic wr(input ocn_byte_t a, input ocn_byte_t d, input bit wait_ack);
		int n;
		n = 0;
		@(posedge sys_clk);
		// busy rises one cycle after a saving write, so look at the settled flag one cycle on
		@(negedge sys_clk);
		// a frequent writer must not talk over a save in progress
		while (wait_ack && bus_ack !== 1'b1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// released lines carry the inverse so stale bytes never look valid
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask

	// commit command: code only, the data lines keep no meaningful byte
	task automatic commit();
		wr(8'h3F, ~reg_wdata, 1'b1);
	endtask

	// one byte read; the note is queued before the taking edge
	task automatic rd(input ocn_byte_t a, input ocn_byte_t e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule

// *** tb.sv ***
// self-checking bench of the oscillator configuration bank
`timescale 1ns/1ps
`include "ocn_osc_map.svh"
module tb;
	import ocn_pkg::*;
	// short save time keeps each commit to a few cycles
	localparam int NVW = 8;
	logic sys_clk, ce, rst, reg_wr, reg_rd, bus_ack, dith, freq_ok;
	logic sa2, sa1, sa0, defer, nv_busy;
	ocn_byte_t reg_addr, reg_wdata, reg_rdata, e, me;
	logic [4:0] band;
	logic [9:0] step, v;
	logic [3:0] dexp;
	logic [15:0] mfreq;
	int num_errors = 0;
	int n_tests = 0;
	int seed = 32'h064c;
	int i;
	// a read was taken on the previous edge
	logic rd_seen = 1'b0;

	////////////////////////////////////////////////////////////////
	// block under test and its host
	ocn_config_regs #(.NV_WRITE_CYCLES(NVW)) ocn_config_regs_inst (.sys_clk(sys_clk), .ce(ce), .rst(rst),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.bus_ack(bus_ack), .band_select(band), .step_value(step), .divider_exponent(dexp),
		.dither_depth_select(dith), .master_freq_10khz(mfreq), .freq_in_range(freq_ok),
		.slave_addr_bit2(sa2), .slave_addr_bit1(sa1), .slave_addr_bit0(sa0), .nv_write_defer(defer),
		.nv_busy(nv_busy));
	ocn_host_model ocn_host_model_inst (.sys_clk(sys_clk), .bus_ack(bus_ack), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

	////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// one comparison, counted
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		n_tests++;
		if (g !== x) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask

	// read data stands one cycle after the taking edge
	always @(posedge sys_clk) begin
		if (rd_seen) begin
			me = ocn_host_model_inst.exp_q.pop_front();
			chk("reg_rdata", {8'h00, me}, {8'h00, reg_rdata});
		end
		rd_seen <= reg_rd;
	end

	// verdict, reached from the main sequence or the watchdog
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		chk("watchdog", 16'h0000, 16'h0001);
		final_report();
	end

	////////////////////////////////////////////////////////////////
	// bounded wait for the save flag to reach b
	task automatic wait_busy(input logic b);
		int n;
		n = 0;
		while (nv_busy !== b && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("nv_busy", {15'h0, b}, {15'h0, nv_busy});
	endtask

	// derived outputs trail the registers by a cycle
	task automatic settle();
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	// reset models power-up: registers reload from the image
	task automatic reset_dut();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		wait_busy(1'b0);
	endtask

	// step is written left justified over two bytes
	task automatic wstep(input logic [9:0] s);
		ocn_host_model_inst.wr(`OCN_ADR_STEP_HI, s[9:2], 1'b1);
		ocn_host_model_inst.wr(`OCN_ADR_STEP_LO, {s[1:0], 6'h00}, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		ce = 1'b1;
		rst = 1'b1;
		reset_dut();
		// factory defaults at the outputs and on readback
		chk("band_select", 16'h0012, band);
		chk("step_value", 16'h01F4, step);
		chk("divider_exponent", 16'h0000, dexp);
		chk("slave_addr", 16'h0000, {sa2, sa1, sa0});
		chk("nv_write_defer", 16'h0000, defer);
		chk("master_freq", 16'd9716, mfreq);
		chk("bus_ack", 16'h0001, bus_ack);
		ocn_host_model_inst.rd(`OCN_ADR_FACTORY, 8'h12);
		ocn_host_model_inst.rd(`OCN_ADR_DIVIDER, 8'hE0);
		ocn_host_model_inst.rd(`OCN_ADR_STEP_HI, 8'h7D);
		ocn_host_model_inst.rd(`OCN_ADR_STEP_LO, 8'h00);
		ocn_host_model_inst.rd(`OCN_ADR_BAND, 8'hF2);
		ocn_host_model_inst.rd(`OCN_ADR_ADDR_CFG, 8'hF0);
		ocn_host_model_inst.rd(8'h20, 8'hFF);
		// the factory copy ignores writes
		ocn_host_model_inst.wr(`OCN_ADR_FACTORY, 8'($random(seed)), 1'b1);
		ocn_host_model_inst.rd(`OCN_ADR_FACTORY, 8'h12);
		// address register saves at once and sets defer
		ocn_host_model_inst.wr(`OCN_ADR_ADDR_CFG, 8'h0D, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk("slave_addr", 16'h0005, {sa2, sa1, sa0});
		chk("nv_write_defer", 16'h0001, defer);
		// band two below factory, step 655, divide by 8: in-range settings
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h10, 1'b1);
		wstep(10'd655);
		ocn_host_model_inst.wr(`OCN_ADR_DIVIDER, 8'h03, 1'b1);
		settle();
		chk("nv_busy", 16'h0000, nv_busy);
		chk("band_select", 16'h0010, band);
		chk("step_value", 16'h028F, step);
		chk("divider_exponent", 16'h0003, dexp);
		chk("dither", 16'h0000, dith);
		chk("master_freq", 16'd8847, mfreq);
		chk("freq_in_range", 16'h0001, freq_ok);
		ocn_host_model_inst.rd(`OCN_ADR_STEP_HI, 8'hA3);
		ocn_host_model_inst.rd(`OCN_ADR_STEP_LO, 8'hC0);
		// every exponent field value, random dither bit
		for (i = 0; i < 16; i++) begin
			e = {3'b000, 1'($random(seed)), 4'(i)};
			ocn_host_model_inst.wr(`OCN_ADR_DIVIDER, e, 1'b1);
			settle();
			chk("divider_exponent", (i > 8) ? 16'd8 : 16'(i), dexp);
			chk("dither", {15'h0, e[4]}, dith);
			ocn_host_model_inst.rd(`OCN_ADR_DIVIDER, {3'b111, e[4:0]});
		end
		// random steps one band above factory
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h13, 1'b1);
		for (i = 0; i < 4; i++) begin
			v = 10'($random(seed));
			wstep(v);
			settle();
			chk("step_value", {6'h00, v}, step);
			chk("master_freq", 16'd9728 + v, mfreq);
		end
		// a band far below factory leaves the valid span
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h05, 1'b1);
		settle();
		chk("master_freq", 16'd2560 + v, mfreq);
		chk("freq_in_range", 16'h0000, freq_ok);
		// commit, with a write thrown at it mid-save
		ocn_host_model_inst.commit();
		wait_busy(1'b1);
		chk("bus_ack", 16'h0000, bus_ack);
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h11, 1'b0);
		wait_busy(1'b0);
		settle();
		chk("band_select", 16'h0005, band);
		reset_dut();
		chk("band_select", 16'h0005, band);
		chk("step_value", {6'h00, v}, step);
		chk("divider_exponent", 16'd8, dexp);
		chk("slave_addr", 16'h0005, {sa2, sa1, sa0});
		// deferred change without commit is lost on reload
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h10, 1'b1);
		reset_dut();
		chk("band_select", 16'h0005, band);
		// a write while the enable is low leaves every register frozen
		@(posedge sys_clk);
		ce <= 1'b0;
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h01, 1'b0);
		ce <= 1'b1;
		settle();
		chk("band_select", 16'h0005, band);
		// factory band with step zero sits on the band base
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h12, 1'b1);
		wstep(10'h000);
		settle();
		chk("master_freq", 16'd9216, mfreq);
		// divider byte 13h: divide by eight with the narrow dither
		ocn_host_model_inst.wr(`OCN_ADR_DIVIDER, 8'h13, 1'b1);
		settle();
		chk("dither", 16'h0001, dith);
		chk("divider_exponent", 16'h0003, dexp);
		// clear defer, then a plain write saves by itself
		ocn_host_model_inst.wr(`OCN_ADR_ADDR_CFG, 8'h02, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		ocn_host_model_inst.wr(`OCN_ADR_BAND, 8'h14, 1'b1);
		wait_busy(1'b1);
		wait_busy(1'b0);
		reset_dut();
		chk("band_select", 16'h0014, band);
		chk("slave_addr", 16'h0002, {sa2, sa1, sa0});
		chk("nv_write_defer", 16'h0000, defer);
		final_report();
	end
endmodule
